// >>> hw/pclp_pkg.sv
// Constants, register map and timing counts of the peak-current LED PWM block
package pclp_pkg;
   // Clock and channel layout
   localparam int CLK_MHZ   = 250;
   localparam int NCH       = 3;
   localparam int CH_RED    = 0;
   localparam int CH_GREEN  = 1;
   localparam int CH_BLUE   = 2;
   localparam int THR_W     = 12;
   localparam int STEP_W    = 8;
   localparam int CNT_W     = 10;
   localparam int JOY_N     = 5;
   // Switching period
   localparam int PERIOD_NS  = 4000;
   localparam int PERIOD_CYC = PERIOD_NS * CLK_MHZ / 1000;
   // Burst repetition
   localparam int BURST_HZ   = 400;
   localparam int BURST_CYC  = CLK_MHZ * 1000000 / BURST_HZ;
   // Triangle generation output
   localparam int TRI_KHZ    = 2000;
   localparam int TRI_CYC    = CLK_MHZ * 1000 / TRI_KHZ;
   localparam int TRI_REP    = 100;
   localparam int TRI_IRQ_US = 50;
   // System tick
   localparam int TICK_MS    = 1;
   localparam int TICK_CYC   = CLK_MHZ * 1000 * TICK_MS;
   // Sawtooth step rates; least step spacing rounds up
   localparam int FAST_KSPS     = 15000;
   localparam int SLOW_KSPS     = 3000;
   localparam int FAST_STEP_CYC = (CLK_MHZ * 1000 + FAST_KSPS - 1) / FAST_KSPS;
   localparam int SLOW_STEP_CYC = (CLK_MHZ * 1000 + SLOW_KSPS - 1) / SLOW_KSPS;
   localparam int FAST_STEPS    = 60;
   localparam int SLOW_STEPS    = 12;
   // Event and trigger slot numbers per channel (red, green, blue)
   localparam int EVT_N  = 8;
   localparam int TRG_N  = 8;
   localparam int red_evt_sel   = 1;
   localparam int green_evt_sel = 5;
   localparam int blue_evt_sel  = 2;
   localparam int red_sawtooth_trigger_sel   = 6;
   localparam int green_sawtooth_trigger_sel = 5;
   localparam int blue_sawtooth_trigger_sel  = 1;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_BURST  = 12'h004;
   localparam logic [11:0] OFS_BLANK  = 12'h008;
   localparam logic [11:0] OFS_THR_R  = 12'h00c;
   localparam logic [11:0] OFS_THR_G  = 12'h010;
   localparam logic [11:0] OFS_THR_B  = 12'h014;
   localparam logic [11:0] OFS_STEP   = 12'h018;
   localparam logic [11:0] OFS_TRI    = 12'h01c;
   localparam logic [11:0] OFS_STATUS = 12'h020;
   localparam logic [11:0] OFS_JOY    = 12'h024;
   // Field positions
   localparam int CTRL_CH_EN  = 0;
   localparam int CTRL_TRI_EN = 3;
   localparam int STAT_TRI    = 3;
   localparam int STAT_BURST  = 4;
   // Reset values
   localparam logic [3:0]        RST_CTRL  = 4'h0;
   localparam logic [CNT_W-1:0]  RST_BURST = 10'h010;
   localparam logic [CNT_W-1:0]  RST_BLANK = 10'h032;
   localparam logic [THR_W-1:0]  RST_THR   = 12'h400;
   localparam logic [STEP_W-1:0] RST_STEP  = 8'h08;
   localparam logic [7:0]        RST_TRI   = 8'h20;
endpackage : pclp_pkg

// >>> hw/pclp_chan_if.sv
// Carrier between the common timer base and one LED channel
interface pclp_chan_if;
   import pclp_pkg::*;
   logic                 period_evt;
   logic                 burst_on;
   logic                 enable;
   logic [CNT_W-1:0]     cnt;
   logic [CNT_W-1:0]     blank_cyc;
   logic [THR_W-1:0]     thr_start;
   logic [STEP_W-1:0]    step_size;
   logic                 evt;
   logic                 rst_in;
   logic                 step_in;
   logic                 pwm;
   logic [THR_W-1:0]     thr;
   logic                 rst_out;
   logic                 step_out;
   modport ctl  (output period_evt, burst_on, enable, cnt, blank_cyc, thr_start, step_size, evt, rst_in, step_in,
                 input  pwm, thr, rst_out, step_out);
   modport chan (input  period_evt, burst_on, enable, cnt, blank_cyc, thr_start, step_size, evt, rst_in, step_in,
                 output pwm, thr, rst_out, step_out);
endinterface : pclp_chan_if

// >>> hw/pclp_chan.sv
// One LED channel: blanked set/reset output and decrementing sawtooth threshold
module pclp_chan
   import pclp_pkg::*;
#(
   parameter int STEP_CYC  = FAST_STEP_CYC,
   parameter int MAX_STEPS = FAST_STEPS
) (
   // Clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // Timer base side
   pclp_chan_if.chan bus
);
   typedef struct packed {
      logic             pwm;
      logic [THR_W-1:0] thr;
      logic [6:0]       steps;
      logic [6:0]       scnt;
   } pclp_chan_st_t;

   pclp_chan_st_t s_ff;
   pclp_chan_st_t nxt_s;
   logic          blanking;
   logic          step_due;

   assign blanking     = bus.cnt < bus.blank_cyc;
   assign step_due     = (s_ff.scnt == 7'(STEP_CYC - 1)) && (s_ff.steps < 7'(MAX_STEPS));
   assign bus.rst_out  = bus.period_evt;
   assign bus.step_out = step_due;
   assign bus.pwm      = s_ff.pwm;
   assign bus.thr      = s_ff.thr;

   always_comb begin
      nxt_s = s_ff;
      // Step phase restarts with every period so the slope stays period locked
      if (bus.period_evt || s_ff.scnt == 7'(STEP_CYC - 1)) begin
         nxt_s.scnt = 7'h00;
      end else begin
         nxt_s.scnt = s_ff.scnt + 7'h01;
      end
      if (bus.rst_in) begin
         nxt_s.thr   = bus.thr_start;
         nxt_s.steps = 7'h00;
      end else if (bus.step_in) begin
         nxt_s.steps = s_ff.steps + 7'h01;
         // Saturate so a large step never wraps to a high threshold
         if (s_ff.thr > THR_W'(bus.step_size)) begin
            nxt_s.thr = s_ff.thr - THR_W'(bus.step_size);
         end else begin
            nxt_s.thr = '0;
         end
      end
      if (bus.period_evt) begin
         nxt_s.pwm = bus.enable && bus.burst_on;
      end else if (bus.evt && !blanking) begin
         nxt_s.pwm = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   a_period_set: assert property (@(posedge pclk) disable iff (!presetn)
      bus.period_evt |=> (s_ff.pwm == $past(bus.enable && bus.burst_on))) else $error("output not set at period");
   a_blank_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.pwm && blanking && !bus.period_evt) |=> s_ff.pwm) else $error("event inside blanking cleared output");
   a_event_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (bus.evt && !blanking && !bus.period_evt) |=> !s_ff.pwm) else $error("unblanked event did not clear output");
   a_stay_low: assert property (@(posedge pclk) disable iff (!presetn)
      (!s_ff.pwm && !bus.period_evt) |=> !s_ff.pwm) else $error("output rose between period events");
   a_hold_high: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.pwm && !bus.evt && !bus.period_evt) |=> s_ff.pwm) else $error("output fell without event");
   a_saw_reload: assert property (@(posedge pclk) disable iff (!presetn)
      bus.rst_in |=> (s_ff.thr == $past(bus.thr_start)) && (s_ff.steps == 7'h00)) else $error("sawtooth not reloaded");
   a_saw_step: assert property (@(posedge pclk) disable iff (!presetn)
      (bus.step_in && !bus.rst_in && s_ff.thr > THR_W'(bus.step_size))
      |=> s_ff.thr == $past(s_ff.thr) - THR_W'($past(bus.step_size))) else $error("sawtooth step wrong");
   a_step_limit: assert property (@(posedge pclk) disable iff (!presetn)
      s_ff.steps <= 7'(MAX_STEPS)) else $error("too many steps in one period");
endmodule : pclp_chan

// >>> hw/pclp_top.sv
// Three-channel peak-current LED PWM with burst, sawtooth, triangle, tick and joystick logic
module pclp_top
   import pclp_pkg::*;
#(
   parameter int BURST_CYCLES = BURST_CYC,
   parameter int TICK_CYCLES  = TICK_CYC,
   parameter int TRI_REPEAT   = TRI_REP
) (
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic [11:0]                paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Current sense codes, one per colour, on pclk
   input  wire logic [NCH-1:0][THR_W-1:0]  sense_code,
   // Joystick lines from pins
   input  wire logic [JOY_N-1:0]           joy_line,
   // Outputs
   output logic      [NCH-1:0]             led_pwm,
   output logic                            tri_pwm,
   output logic                            tri_irq,
   output logic                            tick_irq,
   output logic                            joy_irq,
   output logic      [JOY_N-1:0]           joy_key
);
   localparam int BURST_PER = BURST_CYCLES / PERIOD_CYC;
   localparam int BW        = $clog2(BURST_PER + 1);
   localparam int TW        = $clog2(TICK_CYCLES + 1);
   localparam int RW        = $clog2(TRI_REPEAT + 1);
   localparam int EVT_SEL [NCH] = '{red_evt_sel, green_evt_sel, blue_evt_sel};
   localparam int TRG_SEL [NCH] = '{red_sawtooth_trigger_sel, green_sawtooth_trigger_sel, blue_sawtooth_trigger_sel};

   typedef struct packed {
      logic [CNT_W-1:0]             cnt;
      logic [BW-1:0]                burst;
      logic [TW-1:0]                tick;
      logic                         tick_irq;
      logic [6:0]                   tri_cnt;
      logic [RW-1:0]                tri_rep;
      logic                         tri_out;
      logic                         tri_irq;
      logic [JOY_N-1:0]             joy_s1;
      logic [JOY_N-1:0]             joy_s2;
      logic [JOY_N-1:0]             joy_s3;
      logic [JOY_N-1:0]             joy_flags;
      logic                         joy_irq;
      logic [JOY_N-1:0]             joy_key;
      logic [3:0]                   ctrl;
      logic [CNT_W-1:0]             pulses;
      logic [CNT_W-1:0]             blank;
      logic [NCH-1:0][THR_W-1:0]    thr_start;
      logic [NCH-1:0][STEP_W-1:0]   step;
      logic [7:0]                   tri_duty;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
   } pclp_top_st_t;

   pclp_top_st_t       s_ff;
   pclp_top_st_t       nxt_s;
   logic               period_evt;
   logic [BW-1:0]      burst_next;
   logic               burst_on;
   logic [NCH-1:0]     cmp_out;
   logic [EVT_N-1:0]   evt_vec;
   logic [TRG_N-1:0]   trg_rst;
   logic [TRG_N-1:0]   trg_step;
   logic [NCH-1:0]     rst_out;
   logic [NCH-1:0]     step_out;
   logic [NCH-1:0][THR_W-1:0] thr;
   logic               setup;
   logic               access_wr;
   logic [JOY_N-1:0]   joy_edge;
   logic [JOY_N-1:0]   joy_clr;
   logic [31:0]        rd_word;
   logic               rd_err;

   pclp_chan_if ch_if [NCH] ();

   assign period_evt = s_ff.cnt == CNT_W'(PERIOD_CYC - 1);
   assign burst_next = (s_ff.burst == BW'(BURST_PER - 1)) ? '0 : s_ff.burst + 1'b1;
   // Burst window decided for the period that is about to start
   // Index widened, never the count cut: a short burst would read a large count as zero
   assign burst_on   = CNT_W'(period_evt ? burst_next : s_ff.burst) < s_ff.pulses;

   // Comparators feed only event slots; nothing reaches a pin
   always_comb begin
      evt_vec  = '0;
      trg_rst  = '0;
      trg_step = '0;
      for (int i = 0; i < NCH; i++) begin
         cmp_out[i]          = sense_code[i] > thr[i];
         evt_vec[EVT_SEL[i]] = cmp_out[i];
         trg_rst[TRG_SEL[i]]  = rst_out[i];
         trg_step[TRG_SEL[i]] = step_out[i];
      end
   end

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign ch_if[i].period_evt = period_evt;
      assign ch_if[i].burst_on   = burst_on;
      assign ch_if[i].enable     = s_ff.ctrl[CTRL_CH_EN + i];
      assign ch_if[i].cnt        = s_ff.cnt;
      assign ch_if[i].blank_cyc  = s_ff.blank;
      assign ch_if[i].thr_start  = s_ff.thr_start[i];
      assign ch_if[i].step_size  = s_ff.step[i];
      assign ch_if[i].evt        = evt_vec[EVT_SEL[i]];
      assign ch_if[i].rst_in     = trg_rst[TRG_SEL[i]];
      assign ch_if[i].step_in    = trg_step[TRG_SEL[i]];
      assign rst_out[i]          = ch_if[i].rst_out;
      assign step_out[i]         = ch_if[i].step_out;
      assign thr[i]              = ch_if[i].thr;
      assign led_pwm[i]          = ch_if[i].pwm;
      pclp_chan #(
         .STEP_CYC  ((i == CH_BLUE) ? SLOW_STEP_CYC : FAST_STEP_CYC),
         .MAX_STEPS ((i == CH_BLUE) ? SLOW_STEPS : FAST_STEPS)
      ) u_chan (
         .pclk    (pclk),
         .presetn (presetn),
         .bus     (ch_if[i])
      );
   end

   assign setup     = psel && !penable;
   assign access_wr = psel && penable && s_ff.pready && pwrite;
   assign joy_edge  = s_ff.joy_s2 ^ s_ff.joy_s3;
   // Write one to clear; an edge in the same cycle still sets its flag
   assign joy_clr   = (access_wr && paddr == OFS_JOY) ? pwdata[JOY_N-1:0] : '0;

   always_comb begin
      rd_err  = 1'b0;
      rd_word = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL:   rd_word[3:0]        = s_ff.ctrl;
         OFS_BURST:  rd_word[CNT_W-1:0]  = s_ff.pulses;
         OFS_BLANK:  rd_word[CNT_W-1:0]  = s_ff.blank;
         OFS_THR_R:  rd_word[THR_W-1:0]  = s_ff.thr_start[CH_RED];
         OFS_THR_G:  rd_word[THR_W-1:0]  = s_ff.thr_start[CH_GREEN];
         OFS_THR_B:  rd_word[THR_W-1:0]  = s_ff.thr_start[CH_BLUE];
         OFS_STEP:   rd_word[23:0]       = s_ff.step;
         OFS_TRI:    rd_word[7:0]        = s_ff.tri_duty;
         OFS_STATUS: rd_word[4:0]        = {burst_on, s_ff.tri_out, led_pwm};
         OFS_JOY:    rd_word[JOY_N-1:0]  = s_ff.joy_flags;
         default:    rd_err              = 1'b1;
      endcase
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.cnt = period_evt ? '0 : s_ff.cnt + 1'b1;
      if (period_evt) begin
         nxt_s.burst = burst_next;
      end
      // System tick
      nxt_s.tick_irq = s_ff.tick == TW'(TICK_CYCLES - 1);
      nxt_s.tick     = nxt_s.tick_irq ? '0 : s_ff.tick + 1'b1;
      // Triangle PWM on the red timer's second output
      nxt_s.tri_irq = 1'b0;
      if (s_ff.tri_cnt == 7'(TRI_CYC - 1)) begin
         nxt_s.tri_cnt = 7'h00;
         if (s_ff.tri_rep == RW'(TRI_REPEAT - 1)) begin
            nxt_s.tri_rep = '0;
            nxt_s.tri_irq = s_ff.ctrl[CTRL_TRI_EN];
         end else begin
            nxt_s.tri_rep = s_ff.tri_rep + 1'b1;
         end
      end else begin
         nxt_s.tri_cnt = s_ff.tri_cnt + 7'h01;
      end
      nxt_s.tri_out = s_ff.ctrl[CTRL_TRI_EN] && ({1'b0, s_ff.tri_cnt} < s_ff.tri_duty);
      // Joystick: two-stage synchroniser, then any-edge detect
      nxt_s.joy_s1    = joy_line;
      nxt_s.joy_s2    = s_ff.joy_s1;
      nxt_s.joy_s3    = s_ff.joy_s2;
      nxt_s.joy_flags = (s_ff.joy_flags & ~joy_clr) | joy_edge;
      nxt_s.joy_irq   = |joy_edge;
      if (|joy_edge) begin
         nxt_s.joy_key = joy_edge;
      end
      // APB: answer registered in setup, so access phase completes at once
      nxt_s.pready  = setup;
      if (setup) begin
         nxt_s.prdata  = pwrite ? 32'h0000_0000 : rd_word;
         nxt_s.pslverr = rd_err;
      end
      if (access_wr && !s_ff.pslverr) begin
         unique case (paddr)
            OFS_CTRL:  nxt_s.ctrl              = pwdata[3:0];
            OFS_BURST: nxt_s.pulses            = pwdata[CNT_W-1:0];
            OFS_BLANK: nxt_s.blank             = pwdata[CNT_W-1:0];
            OFS_THR_R: nxt_s.thr_start[CH_RED]   = pwdata[THR_W-1:0];
            OFS_THR_G: nxt_s.thr_start[CH_GREEN] = pwdata[THR_W-1:0];
            OFS_THR_B: nxt_s.thr_start[CH_BLUE]  = pwdata[THR_W-1:0];
            OFS_STEP:  nxt_s.step              = pwdata[23:0];
            OFS_TRI:   nxt_s.tri_duty          = pwdata[7:0];
            default:   nxt_s.tri_duty          = s_ff.tri_duty;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff           <= '0;
         s_ff.ctrl      <= RST_CTRL;
         s_ff.pulses    <= RST_BURST;
         s_ff.blank     <= RST_BLANK;
         s_ff.thr_start <= {NCH{RST_THR}};
         s_ff.step      <= {NCH{RST_STEP}};
         s_ff.tri_duty  <= RST_TRI;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata   = s_ff.prdata;
   assign pready   = s_ff.pready;
   assign pslverr  = s_ff.pslverr;
   assign tri_pwm  = s_ff.tri_out;
   assign tri_irq  = s_ff.tri_irq;
   assign tick_irq = s_ff.tick_irq;
   assign joy_irq  = s_ff.joy_irq;
   assign joy_key  = s_ff.joy_key;

   a_period_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      period_evt |=> (s_ff.cnt == '0) ##1 (s_ff.cnt == CNT_W'(1))) else $error("period counter wrap wrong");
   a_burst_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (period_evt && s_ff.burst == BW'(BURST_PER - 1)) |=> s_ff.burst == '0) else $error("burst did not wrap");
   a_burst_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (period_evt && CNT_W'(burst_next) >= s_ff.pulses) |=> led_pwm == '0) else $error("output active in burst idle");
   a_tick_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      tick_irq |=> !tick_irq && s_ff.tick == TW'(1)) else $error("tick pulse wrong");
   a_tri_irq: assert property (@(posedge pclk) disable iff (!presetn)
      tri_irq |-> $past(s_ff.tri_rep) == RW'(TRI_REPEAT - 1) && s_ff.tri_cnt == 7'h00) else $error("triangle irq misplaced");
   a_joy_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (|joy_edge) |=> joy_irq && ((s_ff.joy_flags & $past(joy_edge)) == $past(joy_edge))) else $error("joystick edge lost");
   a_evt_route: assert property (@(posedge pclk) disable iff (!presetn)
      ch_if[CH_GREEN].evt == cmp_out[CH_GREEN] && evt_vec[red_evt_sel] == cmp_out[CH_RED]) else $error("event slot wrong");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready) else $error("apb ready timing wrong");

   // Channel enable, trigger routing and comparator sense
   a_chan_off: assert property (@(posedge pclk) disable iff (!presetn)
      (period_evt && !s_ff.ctrl[CTRL_CH_EN + CH_BLUE]) |=> !led_pwm[CH_BLUE])
      else $error("disabled channel switched on");
   a_burst_active: assert property (@(posedge pclk) disable iff (!presetn)
      (period_evt && burst_on && s_ff.ctrl[CTRL_CH_EN + CH_RED]) |=> led_pwm[CH_RED])
      else $error("output not set in burst window");
   a_trg_route: assert property (@(posedge pclk) disable iff (!presetn)
      ch_if[CH_BLUE].rst_in == rst_out[CH_BLUE] && ch_if[CH_GREEN].step_in == step_out[CH_GREEN])
      else $error("sawtooth trigger slot wrong");
   a_cmp_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      ch_if[CH_RED].evt == (sense_code[CH_RED] > thr[CH_RED]))
      else $error("comparator polarity wrong");

   // Triangle, register bus and joystick side effects
   a_tri_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.tri_cnt == 7'(TRI_CYC - 1)) |=> (s_ff.tri_cnt == 7'h00))
      else $error("triangle period wrong");
   a_tri_off: assert property (@(posedge pclk) disable iff (!presetn)
      !s_ff.ctrl[CTRL_TRI_EN] |=> !tri_pwm)
      else $error("triangle output without enable");
   a_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> (pslverr == $past(rd_err)))
      else $error("register bus error flag wrong");
   a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == OFS_STATUS) |=> (prdata[STAT_BURST] == $past(burst_on))
      && (prdata[STAT_TRI] == $past(s_ff.tri_out))) else $error("status bits wrong");
   a_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (access_wr && s_ff.pslverr) |=> $stable(s_ff.ctrl) && $stable(s_ff.pulses))
      else $error("unmapped write changed a register");
   a_joy_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (joy_clr != '0 && joy_edge == '0) |=> ((s_ff.joy_flags & $past(joy_clr)) == '0))
      else $error("joystick flag not cleared");
   a_joy_key: assert property (@(posedge pclk) disable iff (!presetn)
      (|joy_edge) |=> (joy_key == $past(joy_edge)))
      else $error("joystick key not captured");
endmodule : pclp_top

// >>> bench/pclp_stage.sv
// Behavioural LED buck stage giving one sense code per colour
module pclp_stage
   import pclp_pkg::*;
(
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // Switch drive and wanted sense level
   input  wire logic [NCH-1:0]            led_pwm,
   input  wire logic [THR_W-1:0]          level,
   // Sense codes back to the block
   output logic      [NCH-1:0][THR_W-1:0] sense_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Current only flows while the switch conducts, one cycle behind it
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < NCH; i++) begin
         if (!presetn) begin
            sense_code[i] <= '0;
         end else begin
            sense_code[i] <= led_pwm[i] ? level : '0;
         end
      end
   end
endmodule : pclp_stage

// >>> bench/pclp_tb.sv
// Self-checking bench of the peak-current LED PWM block
module pclp_tb;
   import pclp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BCYC = 5000;
   localparam logic [11:0] OFS [9] = '{OFS_CTRL, OFS_BURST, OFS_BLANK, OFS_THR_R, OFS_THR_G, OFS_THR_B,
                                       OFS_STEP, OFS_TRI, OFS_JOY};
   localparam logic [31:0] RV [9] = '{32'h0, 32'h10, 32'h32, 32'h400, 32'h400, 32'h400, 32'h80808, 32'h20, 32'h0};
   logic                      pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]               paddr = '0;
   logic [31:0]               pwdata = '0, prdata, rd;
   logic                      pready, pslverr, tri_pwm, tri_irq, tick_irq, joy_irq, er;
   logic [NCH-1:0][THR_W-1:0] sense_code;
   logic [JOY_N-1:0]          joy_line = '0, joy_key;
   logic [NCH-1:0]            led_pwm;
   logic [THR_W-1:0]          level = '0;
   int                        n_mismatch = 0, samples_checked = 0, w;
   int                        cnt [4];
   always #2 pclk = ~pclk;
   pclp_top #(.BURST_CYCLES(BCYC), .TICK_CYCLES(100), .TRI_REPEAT(4)) i_pclp_top (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sense_code(sense_code), .joy_line(joy_line), .led_pwm(led_pwm),
      .tri_pwm(tri_pwm), .tri_irq(tri_irq), .tick_irq(tick_irq), .joy_irq(joy_irq), .joy_key(joy_key));
   pclp_stage i_pclp_stage (.pclk(pclk), .presetn(presetn), .led_pwm(led_pwm), .level(level),
      .sense_code(sense_code));
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task stop(input string nm);
      n_mismatch++;
      $display("mismatch %s expected event seen timeout", nm);
      end_sim();
   endtask : stop
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) stop("pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // High time of the next pulse; a negative expectation only resyncs
   task pulse(input int ch, input int exp);
      int i, n;
      for (i = 0; i < 12000 && led_pwm[ch] !== 1'b0; i++) @(posedge pclk);
      for (i = i; i < 12000 && led_pwm[ch] !== 1'b1; i++) @(posedge pclk);
      if (i == 12000) stop("led rise");
      for (n = 0; n < 3000 && led_pwm[ch] === 1'b1; n++) @(posedge pclk);
      if (exp >= 0) chk("led width", 32'(exp), 32'(n));
   endtask : pulse
   // One whole burst window, so each periodic event shows a fixed count
   task count_burst;
      logic p;
      p = led_pwm[0];
      cnt = '{default: 0};
      repeat (BCYC) begin
         @(posedge pclk);
         if (led_pwm[0] === 1'b1 && p === 1'b0) cnt[0]++;
         cnt[1] += int'(tick_irq === 1'b1);
         cnt[2] += int'(tri_irq === 1'b1);
         cnt[3] += int'(tri_pwm === 1'b1);
         p = led_pwm[0];
      end
   endtask : count_burst
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (w = 0; w < 9; w++) begin
         apb(1'b0, OFS[w], '0);
         chk("reset value", RV[w], rd);
      end
      apb(1'b0, 12'h028, '0);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      $display("test registers done");
      chk("led before enable", 32'h0, 32'(led_pwm));
      apb(1'b1, OFS_BURST, 32'h2);
      apb(1'b1, OFS_CTRL, 32'hf);
      level <= 12'hfff;
      for (w = 0; w < NCH; w++) pulse(w, 32'h32 + 1);
      apb(1'b1, OFS_BLANK, 32'h64);
      pulse(0, 32'h64 + 1);
      apb(1'b1, OFS_BLANK, 32'h32);
      level <= 12'h3f0;
      // Soft start opens from a zero threshold
      apb(1'b1, OFS_THR_R, 32'h0);
      pulse(0, 32'h32 + 1);
      apb(1'b1, OFS_THR_R, 32'h400);
      // Third step of 8 from 0x400 drops below 0x3f0; a step lands one full spacing after reload
      pulse(0, 3 * FAST_STEP_CYC + 1);
      pulse(1, 3 * FAST_STEP_CYC + 1);
      pulse(2, 3 * SLOW_STEP_CYC + 1);
      $display("test clearing done");
      level <= '0;
      pulse(0, -1);
      pulse(0, 2 * PERIOD_CYC);
      apb(1'b0, OFS_STATUS, '0);
      chk("status idle", 32'h0, rd & 32'h17);
      level <= 12'hfff;
      count_burst();
      chk("burst pulses", 32'h2, 32'(cnt[0]));
      chk("tick pulses", 32'(BCYC / 100), 32'(cnt[1]));
      chk("triangle irq", 32'(BCYC / (4 * TRI_CYC)), 32'(cnt[2]));
      chk("triangle high", 32'(BCYC / TRI_CYC * 32), 32'(cnt[3]));
      $display("test timing done");
      joy_line <= 5'b00100;
      for (w = 0; w < 10 && joy_irq !== 1'b1; w++) @(posedge pclk);
      if (w == 10) stop("joy_irq");
      chk("joy key", 32'h4, {27'h0, joy_key});
      apb(1'b0, OFS_JOY, '0);
      chk("joy flags", 32'h4, rd);
      apb(1'b1, OFS_JOY, 32'h4);
      apb(1'b0, OFS_JOY, '0);
      chk("joy cleared", 32'h0, rd);
      $display("test joystick done");
      end_sim();
   end
endmodule : pclp_tb
